// ==== src/fcp_pkg.sv ====
// Constants and types for the flash card host pin logic.
// Assumes a single 50 MHz clock and pins already synchronous to it.
//
// What this block does
// - Card modes take eleven-bit address, A10 MSB
// - IDE mode decodes low three address bits
// - Memory mode drives both battery outputs high
// - I/O mode holds audio output high
// - Card-detect outputs always low
// - Active-low selects plus A0 pick access width
// - IDE: high select alternate regs, low others
// - IDE strap grounded master, open slave
// - Sixteen-bit data, even byte low lane
// - I/O mode acknowledge low on answered read
// - Acknowledge unused in memory and IDE
// - Read strobe ignored in memory mode
// - I/O mode status-change signals config changes
// - IDE exchanges diagnostic and presence signals
// - Memory mode: attribute select high task file, low attribute
package fcp_pkg;
	// ***************************************************
	// Widths
	// ***************************************************
	localparam int ADDR_W     = 11;
	localparam int DATA_W     = 16;
	localparam int IDE_ADDR_W = 3;
	localparam int BYTE_W     = 8;
	localparam logic [1:0] MODE_RST = 2'h0;

	// ***************************************************
	// Types
	// ***************************************************
	typedef enum logic [1:0] {
		FCP_MEM, FCP_IO, FCP_IDE
	} fcp_mode_type;

	typedef enum logic [2:0] {
		FCP_ACC_NONE, FCP_ACC_WORD, FCP_ACC_EVEN, FCP_ACC_ODD,
		FCP_ACC_ODD_HI
	} fcp_acc_type;

	// Select/A0 to access kind, used by decoder and lane mux
	function automatic fcp_acc_type fcp_acc(input logic ce_lo_n,
		input logic ce_hi_n, input logic a0);
		if (ce_lo_n && ce_hi_n)
			return FCP_ACC_NONE;
		else if (!ce_lo_n && !ce_hi_n)
			return FCP_ACC_WORD;
		else if (!ce_lo_n)
			return a0 ? FCP_ACC_ODD : FCP_ACC_EVEN;
		else
			return FCP_ACC_ODD_HI;
	endfunction
endpackage

// ==== src/fcp_addr_dec.sv ====
// Address and select decoder for the card pin logic.
// Combinational; the top module registers mode but feeds select and address pins raw.
module fcp_addr_dec
	import fcp_pkg::*;
(
	// Mode and selects
	input  wire fcp_mode_type         mode_in,
	input  wire logic                 ce_lo_n_in,
	input  wire logic                 ce_hi_n_in,
	input  wire logic                 attr_n_in,
	input  wire logic [ADDR_W-1:0]    addr_in,
	// Decoded
	output wire logic [ADDR_W-1:0]    eff_addr_out,
	output wire fcp_acc_type          acc_out,
	output wire logic                 attr_sel_out,
	output wire logic                 ide_alt_sel_out,
	output wire logic                 ide_tf_sel_out
);
	wire logic is_ide = (mode_in == FCP_IDE);

	// IDE keeps only the low bits; host grounds the rest anyway
	assign eff_addr_out = is_ide ?
		{{(ADDR_W-IDE_ADDR_W){1'b0}}, addr_in[IDE_ADDR_W-1:0]} :
		addr_in;
	assign acc_out = fcp_acc(ce_lo_n_in, ce_hi_n_in, addr_in[0]);
	// Attribute space only in memory mode with select low
	assign attr_sel_out = (mode_in == FCP_MEM) && !attr_n_in;
	assign ide_alt_sel_out = is_ide && !ce_hi_n_in;
	assign ide_tf_sel_out  = is_ide && !ce_lo_n_in;
endmodule

// ==== src/fcp_lane_mux.sv ====
// Byte lane steering for read data onto the card data bus.
// Assumes a 16-bit internal read word, even byte low.
module fcp_lane_mux
	import fcp_pkg::*;
(
	// Access and data
	input  wire fcp_acc_type          acc_in,
	input  wire logic [DATA_W-1:0]    rd_word_in,
	// Pin side
	output wire logic [DATA_W-1:0]    pin_data_out,
	output wire logic                 pin_oe_out
);
	wire logic [BYTE_W-1:0] even_b = rd_word_in[BYTE_W-1:0];
	wire logic [BYTE_W-1:0] odd_b  = rd_word_in[DATA_W-1:BYTE_W];

	// Odd byte with only low select comes out on the low lane
	assign pin_data_out =
		(acc_in == FCP_ACC_WORD)   ? rd_word_in :
		(acc_in == FCP_ACC_EVEN)   ? {8'h00, even_b} :
		(acc_in == FCP_ACC_ODD)    ? {8'h00, odd_b} :
		(acc_in == FCP_ACC_ODD_HI) ? {odd_b, 8'h00} :
		16'h0000;
	assign pin_oe_out = (acc_in != FCP_ACC_NONE);
endmodule

// ==== src/fcp_pin_logic.sv ====
// Top of the card host pin logic: mode, selects, strobes, status pins.
// Assumes the host side pins are synchronous to clk_in; the internal
// register file sits elsewhere and supplies read data and status.
module fcp_pin_logic
	import fcp_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_in,
	// Host address and control
	input  wire logic [ADDR_W-1:0]    addr_in,
	input  wire logic                 card_select_low_n_in,
	input  wire logic                 card_select_high_n_in,
	input  wire logic                 attr_select_n_in,
	input  wire logic                 io_read_strobe_n_in,
	input  wire logic                 ide_mode_select_n_in,
	input  wire logic                 primary_secondary_select_n_in,
	// Internal side
	input  wire logic                 io_configured_in,
	input  wire logic                 io_addr_valid_in,
	input  wire logic                 config_changed_in,
	input  wire logic [DATA_W-1:0]    rd_word_in,
	input  wire logic                 own_diag_pass_in,
	input  wire logic                 own_active_in,
	// Two-way handshake pins, input halves
	input  wire logic                 pass_diagnostic_n_in,
	input  wire logic                 drive_active_secondary_present_n_in,
	// Data bus
	output logic [DATA_W-1:0]         data_out,
	output logic [DATA_W-1:0]         data_oe_out,
	// Status pins (shared pin 46 / 45 roles)
	output logic                      battery_status_one_out,
	output logic                      battery_status_one_oe_out,
	output logic                      battery_status_two_out,
	output logic                      battery_status_two_oe_out,
	// Fixed and acknowledge outputs
	output logic                      card_detect_one_n_out,
	output logic                      card_detect_two_n_out,
	output logic                      input_acknowledge_n_out,
	// Internal decode results
	output logic                      is_master_out,
	output logic                      other_drive_present_out,
	output logic                      other_diag_passed_out,
	output logic                      attr_access_out,
	output logic                      ide_alt_sel_out,
	output logic                      ide_tf_sel_out,
	output logic                      task_read_out,
	output logic [ADDR_W-1:0]         eff_addr_out
);
	// ***************************************************
	// Mode selection
	// ***************************************************
	fcp_mode_type mode_ff;
	fcp_mode_type nxt_mode;
	logic         strap_done_ff;

	// Mode is IDE when mode select grounded, otherwise I/O once configured
	assign nxt_mode = !ide_mode_select_n_in ? FCP_IDE :
		(io_configured_in ? FCP_IO : FCP_MEM);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_ff <= fcp_mode_type'(MODE_RST);
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// Master/slave strap caught once after reset release; the strap
	// means nothing outside IDE mode, so the card reads as slave there
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			strap_done_ff <= 1'b0;
			is_master_out <= 1'b0;
		end else if (!strap_done_ff) begin
			strap_done_ff <= 1'b1;
			is_master_out <= !ide_mode_select_n_in &&
				!primary_secondary_select_n_in;
		end
	end

	// ***************************************************
	// Decode
	// ***************************************************
	wire logic [ADDR_W-1:0] dec_addr;
	fcp_acc_type            dec_acc;
	wire logic              dec_attr;
	wire logic              dec_alt;
	wire logic              dec_tf;

	fcp_addr_dec u_dec (
		.mode_in         (mode_ff),
		.ce_lo_n_in      (card_select_low_n_in),
		.ce_hi_n_in      (card_select_high_n_in),
		.attr_n_in       (attr_select_n_in),
		.addr_in         (addr_in),
		.eff_addr_out    (dec_addr),
		.acc_out         (dec_acc),
		.attr_sel_out    (dec_attr),
		.ide_alt_sel_out (dec_alt),
		.ide_tf_sel_out  (dec_tf)
	);

	// Strobe honoured only outside memory mode and once configured
	wire logic selected = (dec_acc != FCP_ACC_NONE);
	wire logic rd_ok = (mode_ff != FCP_MEM) && io_configured_in &&
		selected && !io_read_strobe_n_in;
	wire logic ack_now = (mode_ff == FCP_IO) && rd_ok &&
		io_addr_valid_in;

	// ***************************************************
	// Data lanes
	// ***************************************************
	wire logic [DATA_W-1:0] lane_data;
	wire logic              lane_oe;
	fcp_acc_type            lane_acc;

	// Lanes only open for an honoured read
	assign lane_acc = rd_ok ? dec_acc : FCP_ACC_NONE;

	fcp_lane_mux u_lane (
		.acc_in       (lane_acc),
		.rd_word_in   (rd_word_in),
		.pin_data_out (lane_data),
		.pin_oe_out   (lane_oe)
	);

	// Registered pin drive; bus floats when nothing is read
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			data_out    <= 16'h0000;
			data_oe_out <= 16'h0000;
		end else begin
			data_out    <= lane_data;
			data_oe_out <= {DATA_W{lane_oe}};
		end
	end

	// ***************************************************
	// Status and handshake pins
	// ***************************************************
	logic nxt_p46;
	logic nxt_p45;

	// Pin 46: battery in memory, status change in I/O, diag in IDE
	assign nxt_p46 = (mode_ff == FCP_MEM) ? 1'b1 :
		(mode_ff == FCP_IO) ? !config_changed_in :
		!own_diag_pass_in;
	// Pin 45: battery, audio held high, or drive active
	assign nxt_p45 = (mode_ff == FCP_MEM) ? 1'b1 :
		(mode_ff == FCP_IO) ? 1'b1 :
		!own_active_in;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			battery_status_one_out    <= 1'b1;
			battery_status_one_oe_out <= 1'b0;
			battery_status_two_out    <= 1'b1;
			battery_status_two_oe_out <= 1'b0;
		end else begin
			battery_status_one_out    <= nxt_p46;
			// Open-drain style in IDE: drive only the low level
			battery_status_one_oe_out <= (mode_ff != FCP_IDE) || !nxt_p46;
			battery_status_two_out    <= nxt_p45;
			battery_status_two_oe_out <= (mode_ff != FCP_IDE) || !nxt_p45;
		end
	end

	// Detect pins tied low; acknowledge and sampled handshakes
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			card_detect_one_n_out   <= 1'b0;
			card_detect_two_n_out   <= 1'b0;
			input_acknowledge_n_out <= 1'b1;
			other_diag_passed_out   <= 1'b0;
			other_drive_present_out <= 1'b0;
		end else begin
			card_detect_one_n_out   <= 1'b0;
			card_detect_two_n_out   <= 1'b0;
			input_acknowledge_n_out <= !ack_now;
			other_diag_passed_out   <= (mode_ff == FCP_IDE) &&
				!pass_diagnostic_n_in;
			other_drive_present_out <= (mode_ff == FCP_IDE) &&
				!drive_active_secondary_present_n_in;
		end
	end

	// ***************************************************
	// Decoded access outputs
	// ***************************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			attr_access_out <= 1'b0;
			ide_alt_sel_out <= 1'b0;
			ide_tf_sel_out  <= 1'b0;
			task_read_out   <= 1'b0;
			eff_addr_out    <= 11'h000;
		end else begin
			attr_access_out <= dec_attr && selected;
			ide_alt_sel_out <= dec_alt;
			ide_tf_sel_out  <= dec_tf;
			task_read_out   <= rd_ok;
			eff_addr_out    <= dec_addr;
		end
	end
endmodule

// ==== tb/fcp_host_model.sv ====
// Host slot model: mode select, address grounding, handshake wires.
// Assumes pull-ups on the two shared handshake pins.
module fcp_host_model
	import fcp_pkg::*;
(
	// Bench requests
	input  wire logic              ide_in,
	input  wire logic              bad_in,
	input  wire logic [ADDR_W-1:0] a_in,
	input  wire logic              diag_low_in,
	input  wire logic              act_low_in,
	// Card pin halves and resolved pins
	input  wire logic              pd_out_in,
	input  wire logic              pd_oe_in,
	input  wire logic              da_out_in,
	input  wire logic              da_oe_in,
	output wire logic [ADDR_W-1:0] addr_out,
	output wire logic              mode_n_out,
	output wire logic              pd_n_out,
	output wire logic              da_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Grounding high address is ours; bad_in breaks it on purpose
	assign addr_out = (ide_in && !bad_in) ? {8'h00, a_in[2:0]} : a_in;
	assign mode_n_out = !ide_in;
	// Pull-up wins unless some party sinks the line
	assign pd_n_out = !((pd_oe_in && !pd_out_in) || diag_low_in);
	assign da_n_out = !((da_oe_in && !da_out_in) || act_low_in);
endmodule

// ==== tb/fcp_pin_logic_monitor.sv ====
// Checker for the card pin logic, bound to its top module.
// Assumes host pins are synchronous to clk_in.
module fcp_pin_logic_monitor
	import fcp_pkg::*;
(
	// Clock, reset and host pins
	input wire logic              clk_in,
	input wire logic              rst_in,
	input wire logic              card_select_low_n_in,
	input wire logic              card_select_high_n_in,
	input wire logic              io_read_strobe_n_in,
	input wire logic              ide_mode_select_n_in,
	input wire logic              io_configured_in,
	input wire logic              io_addr_valid_in,
	// Card outputs
	input wire logic [DATA_W-1:0] data_oe_out,
	input wire logic              battery_status_one_out,
	input wire logic              battery_status_one_oe_out,
	input wire logic              battery_status_two_out,
	input wire logic              battery_status_two_oe_out,
	input wire logic              card_detect_one_n_out,
	input wire logic              card_detect_two_n_out,
	input wire logic              input_acknowledge_n_out,
	input wire logic              task_read_out,
	input wire logic [ADDR_W-1:0] eff_addr_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Mode as seen at the pins; outputs lag up to two edges
	wire mem_c = ide_mode_select_n_in && !io_configured_in;
	wire io_c  = ide_mode_select_n_in && io_configured_in;
	wire sel_c = !(card_select_low_n_in && card_select_high_n_in);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	chk_detect_low: assert property (
		!card_detect_one_n_out && !card_detect_two_n_out)
		else $error("card detect not low");
	chk_battery_high: assert property ((mem_c)[*3] |->
		battery_status_one_out && battery_status_one_oe_out &&
		battery_status_two_out && battery_status_two_oe_out)
		else $error("battery pins not driven high");
	chk_audio_high: assert property ((io_c)[*3] |->
		battery_status_two_out && battery_status_two_oe_out)
		else $error("audio pin not driven high");
	chk_ack_answer: assert property ((io_c && sel_c &&
		!io_read_strobe_n_in && io_addr_valid_in)[*3] |->
		!input_acknowledge_n_out) else $error("ack missing");
	chk_ack_unused: assert property ((!io_c)[*3] |->
		input_acknowledge_n_out) else $error("ack outside io mode");
	chk_strobe_ignored: assert property ((mem_c)[*3] |->
		!task_read_out) else $error("strobe used in memory mode");
	chk_ide_addr: assert property ((!ide_mode_select_n_in)[*3] |->
		eff_addr_out[10:3] == 8'h00) else $error("high address used");
	chk_bus_float: assert property ((!sel_c)[*3] |->
		data_oe_out == 16'h0000) else $error("bus driven unselected");
endmodule

bind fcp_pin_logic fcp_pin_logic_monitor mon (
	.clk_in(clk_in),
	.rst_in(rst_in),
	.card_select_low_n_in(card_select_low_n_in),
	.card_select_high_n_in(card_select_high_n_in),
	.io_read_strobe_n_in(io_read_strobe_n_in),
	.ide_mode_select_n_in(ide_mode_select_n_in),
	.io_configured_in(io_configured_in),
	.io_addr_valid_in(io_addr_valid_in),
	.data_oe_out(data_oe_out),
	.battery_status_one_out(battery_status_one_out),
	.battery_status_one_oe_out(battery_status_one_oe_out),
	.battery_status_two_out(battery_status_two_out),
	.battery_status_two_oe_out(battery_status_two_oe_out),
	.card_detect_one_n_out(card_detect_one_n_out),
	.card_detect_two_n_out(card_detect_two_n_out),
	.input_acknowledge_n_out(input_acknowledge_n_out),
	.task_read_out(task_read_out),
	.eff_addr_out(eff_addr_out)
);

// ==== tb/tb.sv ====
// Bench for the card pin logic: strap, IDE, I/O and memory scenarios.
// Assumes the host model keeps the slot-side pin duties.
module tb
	import fcp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Bench-driven pins; names match the uut ports they feed
	logic clk_in = 0, rst_in = 1, ide = 1, bad = 0, dlow = 0, alow = 0;
	logic card_select_low_n_in = 1, card_select_high_n_in = 1;
	logic attr_select_n_in = 1, io_read_strobe_n_in = 1;
	logic primary_secondary_select_n_in = 0, io_configured_in = 1;
	logic io_addr_valid_in = 0, config_changed_in = 0;
	logic own_diag_pass_in = 0, own_active_in = 0;
	logic [ADDR_W-1:0] a = 0, addr_in, eff_addr_out;
	logic [DATA_W-1:0] rd_word_in = 16'hA55A, data_out, data_oe_out;
	logic ide_mode_select_n_in, pass_diagnostic_n_in, is_master_out;
	logic drive_active_secondary_present_n_in, task_read_out;
	logic battery_status_one_out, battery_status_one_oe_out;
	logic battery_status_two_out, battery_status_two_oe_out;
	logic card_detect_one_n_out, card_detect_two_n_out, attr_access_out;
	logic input_acknowledge_n_out, other_drive_present_out;
	logic other_diag_passed_out, ide_alt_sel_out, ide_tf_sel_out;
	// Lane table: word, even, odd, high-odd, none
	logic [4:0] sl = 5'h18, sh = 5'h16, s0 = 5'h0C;
	logic [15:0] mk [5] = '{16'hFFFF, 16'h00FF, 16'h00FF, 16'hFF00, 16'h0000};
	logic [15:0] ex [5] = '{16'hA55A, 16'h005A, 16'h00A5, 16'hA500, 16'h0000};
	int fails = 0, checked = 0, cyc = 0;
	fcp_pin_logic uut (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.addr_in(addr_in),
		.card_select_low_n_in(card_select_low_n_in),
		.card_select_high_n_in(card_select_high_n_in),
		.attr_select_n_in(attr_select_n_in),
		.io_read_strobe_n_in(io_read_strobe_n_in),
		.ide_mode_select_n_in(ide_mode_select_n_in),
		.primary_secondary_select_n_in(primary_secondary_select_n_in),
		.io_configured_in(io_configured_in),
		.io_addr_valid_in(io_addr_valid_in),
		.config_changed_in(config_changed_in),
		.rd_word_in(rd_word_in),
		.own_diag_pass_in(own_diag_pass_in),
		.own_active_in(own_active_in),
		.pass_diagnostic_n_in(pass_diagnostic_n_in),
		.drive_active_secondary_present_n_in(
			drive_active_secondary_present_n_in),
		.data_out(data_out),
		.data_oe_out(data_oe_out),
		.battery_status_one_out(battery_status_one_out),
		.battery_status_one_oe_out(battery_status_one_oe_out),
		.battery_status_two_out(battery_status_two_out),
		.battery_status_two_oe_out(battery_status_two_oe_out),
		.card_detect_one_n_out(card_detect_one_n_out),
		.card_detect_two_n_out(card_detect_two_n_out),
		.input_acknowledge_n_out(input_acknowledge_n_out),
		.is_master_out(is_master_out),
		.other_drive_present_out(other_drive_present_out),
		.other_diag_passed_out(other_diag_passed_out),
		.attr_access_out(attr_access_out),
		.ide_alt_sel_out(ide_alt_sel_out),
		.ide_tf_sel_out(ide_tf_sel_out),
		.task_read_out(task_read_out),
		.eff_addr_out(eff_addr_out)
	);
	fcp_host_model host (.ide_in(ide), .bad_in(bad), .a_in(a),
		.diag_low_in(dlow), .act_low_in(alow),
		.pd_out_in(battery_status_one_out),
		.pd_oe_in(battery_status_one_oe_out),
		.da_out_in(battery_status_two_out),
		.da_oe_in(battery_status_two_oe_out), .addr_out(addr_in),
		.mode_n_out(ide_mode_select_n_in), .pd_n_out(pass_diagnostic_n_in),
		.da_n_out(drive_active_secondary_present_n_in));
	// Clock, and a ceiling far above the fewer than seventy cycles needed
	always #10 clk_in = !clk_in;
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			fails++;
			final_report;
		end
	end
	task chk(input string n, input logic [15:0] s, e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task final_report;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Mode changes add an edge, so wait three and read at the fall
	task settle;
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	task drv(input logic lo, hi, a0, rs);
		@(posedge clk_in);
		card_select_low_n_in <= lo;
		card_select_high_n_in <= hi;
		a <= {a[ADDR_W-1:1], a0};
		io_read_strobe_n_in <= rs;
		settle;
	endtask
	task reset(input logic strap);
		@(posedge clk_in);
		primary_secondary_select_n_in <= strap;
		rst_in <= 1;
		repeat (3) @(posedge clk_in);
		rst_in <= 0;
		settle;
		chk("master", is_master_out, !strap);
	endtask
	task t_ide;
		drv(1, 0, 0, 1);
		chk("alt", {ide_alt_sel_out, ide_tf_sel_out}, 2);
		drv(0, 1, 0, 0);
		chk("tf", {ide_alt_sel_out, ide_tf_sel_out}, 1);
		chk("rd", {task_read_out, input_acknowledge_n_out}, 3);
		@(posedge clk_in);
		dlow <= 1;
		alow <= 1;
		bad <= 1;
		a <= 11'h7FD;
		settle;
		chk("other", {other_diag_passed_out, other_drive_present_out}, 3);
		chk("low3", eff_addr_out, 16'h0005);
		@(posedge clk_in);
		dlow <= 0;
		own_diag_pass_in <= 1;
		own_active_in <= 1;
		io_configured_in <= 0;
		settle;
		chk("pass_diagnostic_n", {battery_status_one_oe_out, battery_status_one_out}, 2);
		chk("drive_active_secondary_present_n", {battery_status_two_oe_out,
			battery_status_two_out}, 2);
		chk("unconf", task_read_out, 0);
	endtask
	task t_io;
		@(posedge clk_in);
		ide <= 0;
		io_configured_in <= 1;
		io_addr_valid_in <= 1;
		config_changed_in <= 1;
		a <= 11'h5A4;
		settle;
		chk("addr", eff_addr_out, 16'h05A4);
		chk("audio", {battery_status_two_oe_out, battery_status_two_out}, 3);
		chk("status_change_n", battery_status_one_out, 0);
		for (int i = 0; i < 5; i++) begin
			drv(sl[i], sh[i], s0[i], 0);
			chk("lane", data_out & mk[i], ex[i]);
			chk("oe", data_oe_out, i < 4 ? 16'hFFFF : 16'h0000);
			chk("ack", input_acknowledge_n_out, i > 3);
		end
	endtask
	task t_mem;
		@(posedge clk_in);
		io_configured_in <= 0;
		attr_select_n_in <= 0;
		drv(0, 1, 0, 0);
		chk("bvd", {battery_status_one_oe_out, battery_status_one_out,
			battery_status_two_oe_out, battery_status_two_out}, 15);
		chk("strobe", {task_read_out, input_acknowledge_n_out}, 1);
		chk("attr", attr_access_out, 1);
		@(posedge clk_in);
		attr_select_n_in <= 1;
		settle;
		chk("task", attr_access_out, 0);
	endtask
	// Main sequence
	initial begin
		reset(0);
		chk("cd", {card_detect_one_n_out, card_detect_two_n_out}, 0);
		t_ide;
		reset(1);
		t_io;
		t_mem;
		final_report;
	end
endmodule
